// ### design/tadm_pkg.sv
package tadm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALM_CFG  = 8'h60;
  localparam logic [7:0] ADDR_ALM_EN   = 8'h61;
  localparam logic [7:0] ADDR_ALM_STAT = 8'h62;
  localparam logic [7:0] ADDR_ALM_DET  = 8'h63;
  localparam logic [7:0] ADDR_RX_DENS  = 8'h65;
  localparam logic [7:0] ADDR_TX_CODE  = 8'h67;
  localparam logic [7:0] ADDR_TX_DENS  = 8'h69;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ALM_CFG_FMODE_LSB = 2;
  localparam int ALM_EN_FASTD      = 4;
  localparam int ALM_EN_ACCEL      = 3;
  localparam int ALM_STAT_CHG_LSB  = 3;
  localparam int DENS_PDV          = 4;
  localparam int DENS_Z16I         = 3;
  localparam int DENS_DENSITY_CHANGE_FLAG         = 2;
  localparam int DENS_Z16E         = 1;
  localparam int DENS_DENSITY_CHANGE_IRQ_ENABLE         = 0;
  localparam int TXD_STUFF_IRQ_ENABLE         = 7;
  localparam int TXD_STUFF         = 6;
  localparam int TXD_STUFF_OCCURRED_FLAG         = 5;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_OFF    = 6'h3f;
  localparam logic [2:0] FM_SF       = 3'h0;
  localparam logic [2:0] FM_DM       = 3'h1;
  localparam logic [2:0] FM_SLC      = 3'h2;
  localparam logic [2:0] FM_ALT_DM   = 3'h3;
  localparam logic [2:0] FM_ESF      = 3'h4;

  // ----------------------------------------------------------------
  // timing and thresholds
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 25_000_000;
  localparam int RED_WIN_MS   = 40;
  localparam int AIS_WIN_MS   = 60;
  localparam int RED_WIN_CYC  = RED_WIN_MS * (CLK_HZ / 1000);
  localparam int AIS_WIN_CYC  = AIS_WIN_MS * (CLK_HZ / 1000);
  localparam int WIN_CNT_W    = 21;
  localparam int SF_B2_MAX    = 16;
  localparam int DM_Y_MAX     = 4;
  localparam int ESF_CODE_MIN = 8;
  localparam int AIS_ZERO_MAX = 126;
  localparam int DENS_WIN     = 192;
  localparam int DENS_MIN_ONE = 24;
  localparam int ZRUN_LEN     = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tadm_up_req_s;

  typedef struct packed {
    logic oof;
    logic bit2_zero;
    logic ybit_zero;
    logic yel_code_ok;
    logic f12_strobe;
    logic f12_val;
    logic data;
    logic data_valid;
  } tadm_rx_evt_s;

  typedef struct packed {
    logic data;
    logic valid;
    logic fdl_slot;
    logic fdl;
  } tadm_tx_in_s;

endpackage

// ### design/tadm_top.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// density checker over a moving window
// ------------------------------------------------------------------
module tadm_density
  import tadm_pkg::*;
#(
  parameter int WIN      = DENS_WIN,
  parameter int MIN_ONES = DENS_MIN_ONE,
  parameter int ZRUN     = ZRUN_LEN
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic clear_in,
  // bit stream
  input  wire logic bit_valid_in,
  input  wire logic bit_in,
  // results
  output logic      viol_out,
  output logic      chg_out,
  output logic      z16_out,
  output logic      zero_viol_out
);

  typedef struct packed {
    logic [WIN-1:0] hist;
    logic [7:0]     ones;
    logic [4:0]     zrun;
    logic           viol, chg, z16;
  } tadm_dens_s;

  localparam tadm_dens_s D_RST = '{hist: '1, ones: 8'(WIN), zrun: 5'h00,
                                   viol: 1'b0, chg: 1'b0, z16: 1'b0};
  tadm_dens_s s, next_s;

  function automatic logic [7:0] ones_after(input logic [7:0] o, input logic b,
                                            input logic old);
    ones_after = o + {7'h00, b} - {7'h00, old};
  endfunction

  always_comb begin
    logic [7:0] z_ones, b_ones;
    logic [4:0] z_run, b_run;
    logic       b_viol;
    z_ones = ones_after(s.ones, 1'b0, s.hist[WIN-1]);
    z_run  = (s.zrun >= 5'(ZRUN)) ? s.zrun : s.zrun + 5'h01;
    b_ones = ones_after(s.ones, bit_in, s.hist[WIN-1]);
    b_run  = bit_in ? 5'h00 : z_run;
    b_viol = (b_ones < 8'(MIN_ONES)) || (b_run >= 5'(ZRUN));
    zero_viol_out = (z_ones < 8'(MIN_ONES)) || (z_run >= 5'(ZRUN));
    next_s     = s;
    next_s.chg = 1'b0;
    next_s.z16 = 1'b0;
    if (bit_valid_in) begin
      next_s.hist = {s.hist[WIN-2:0], bit_in};
      next_s.ones = b_ones;
      next_s.zrun = b_run;
      next_s.viol = b_viol;
      next_s.chg  = b_viol != s.viol;
      next_s.z16  = (b_run == 5'(ZRUN)) && (s.zrun == 5'(ZRUN - 1));
    end
    if (clear_in) begin
      next_s = D_RST;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= D_RST;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign viol_out = s.viol;
  assign chg_out  = s.chg;
  assign z16_out  = s.z16;

endmodule

// ------------------------------------------------------------------
// T1 alarm, density and loop code maintenance
// ------------------------------------------------------------------
// What this block does
// - Alarm status bits 5:3 latch alarm changes; reading clears them and interrupt.
// - Alarm status bits 2:0 show present Yellow, Red and AIS state.
// - All registers held at reset while E1 mode is selected.
// - Red detect set when any out-of-frame occurred in last 40 ms.
// - SF/SLC: Yellow when bit 2 zero at most 16 times in 40 ms.
// - T1DM: Yellow when Y-bit zero at most 4 times in 40 ms.
// - ESF: Yellow when the Yellow code arrived error-free 8 or more times.
// - Japanese mode: toggling 12th framing bit signals Yellow.
// - AIS when out-of-frame all 60 ms and data zero at most 126 times.
// - Receive density register accessible only while analog bypass select is zero.
// - Density violation state follows the violation live, even one bit long.
// - Density change flag sets on either edge of violation; read clears.
// - Zero run flag sets on 16 consecutive zeros; read clears.
// - Density flags latch regardless of enables; enables gate interrupt only.
// - Interrupt on zero run and on violation onset and end when enabled.
// - Non-all-ones code sent repeatedly as 8 ones, 0, code LSB first, 0.
// - Writing all ones to the code register disables the code generator.
// - With stuffing on, ones are stuffed so output never violates density.
// - With stuffing off, data passes unchanged and violations set change flag.
// - Each stuff sets stuff flag and interrupt if enabled; read clears both.
// - Stuffing on forces transmit violation state and both flags to zero.
// - Each alarm change interrupts only with its own independent enable.
module tadm_top
  import tadm_pkg::*;
#(
  parameter int RED_CYC = RED_WIN_CYC,
  parameter int AIS_CYC = AIS_WIN_CYC
) (
  // clock, reset, enable
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clk_en_in,
  // global configuration
  input  wire logic         e1_mode_select_in,
  input  wire logic         analog_bypass_select_in,
  input  wire logic         japan_mode_in,
  // microprocessor access
  input  wire tadm_up_req_s up_req_in,
  output logic [7:0]        up_rdata_out,
  output logic              interrupt_out_n,
  // receive events and stream
  input  wire tadm_rx_evt_s rx_evt_in,
  // transmit stream
  input  wire tadm_tx_in_s  tx_in,
  output logic              tx_data_out,
  output logic              tx_fdl_out
);

  typedef struct packed {
    logic [2:0]           fmode, alm_en, alm_chg, yz;
    logic [WIN_CNT_W-1:0] t40, t60;
    logic [4:0]           b2z;
    logic [3:0]           code_ok, boc_idx;
    logic [6:0]           azero;
    logic [5:0]           code;
    logic [7:0]           rdata;
    logic                 fastd, accel, red_d, yel_d, ais_d;
    logic                 oof_seen, oof_all, jy_prev, jy_seen, jy_ok;
    logic                 rx_density_change_flag, rx_z16i, rx_z16e, rx_density_change_irq_enable;
    logic                 stuff_irq_enable, stuff, stuff_occurred_flag;
    logic                 tx_density_change_flag, tx_z16i, tx_z16e, tx_density_change_irq_enable;
    logic                 irq_n, tx_data, tx_fdl;
  } tadm_state_s;

  localparam tadm_state_s S_RST = '{code: CODE_OFF, oof_all: 1'b1, jy_ok: 1'b1,
                                    irq_n: 1'b1, default: '0};
  tadm_state_s s, next_s;
  logic        rx_viol, rx_chg, rx_z16;
  logic        tx_viol, tx_chg, tx_z16, tx_zero_viol;
  logic        tx_bit, stuff_evt;

  // ----------------------------------------------------------------
  // density checkers
  // ----------------------------------------------------------------
  assign stuff_evt = tx_in.valid && s.stuff && tx_zero_viol && !tx_in.data;
  assign tx_bit    = tx_in.data | stuff_evt;

  tadm_density u_rx_dens (
    .clk_in        (mclk_in),
    .rst_in        (sys_rst_in),
    .ce_in         (clk_en_in),
    .clear_in      (e1_mode_select_in),
    .bit_valid_in  (rx_evt_in.data_valid),
    .bit_in        (rx_evt_in.data),
    .viol_out      (rx_viol),
    .chg_out       (rx_chg),
    .z16_out       (rx_z16),
    .zero_viol_out ()
  );

  tadm_density u_tx_dens (
    .clk_in        (mclk_in),
    .rst_in        (sys_rst_in),
    .ce_in         (clk_en_in),
    .clear_in      (e1_mode_select_in),
    .bit_valid_in  (tx_in.valid),
    .bit_in        (tx_bit),
    .viol_out      (tx_viol),
    .chg_out       (tx_chg),
    .z16_out       (tx_z16),
    .zero_viol_out (tx_zero_viol)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        end40, end60, yel, rd_alm, rd_rx, rd_tx, wr;
    logic [2:0]  old_alm;
    logic [15:0] pat;
    end40   = s.t40 == WIN_CNT_W'(RED_CYC - 1);
    end60   = s.t60 == WIN_CNT_W'(AIS_CYC - 1);
    wr      = up_req_in.wr;
    rd_alm  = up_req_in.rd && (up_req_in.addr == ADDR_ALM_STAT);
    rd_rx   = up_req_in.rd && (up_req_in.addr == ADDR_RX_DENS) && !analog_bypass_select_in;
    rd_tx   = up_req_in.rd && (up_req_in.addr == ADDR_TX_DENS);
    old_alm = {s.yel_d, s.red_d, s.ais_d};
    pat     = {1'b0, s.code, 1'b0, 8'hff};
    yel     = 1'b0;
    next_s  = s;

    // window timers
    next_s.t40 = end40 ? '0 : s.t40 + WIN_CNT_W'(1);
    next_s.t60 = end60 ? '0 : s.t60 + WIN_CNT_W'(1);

    // per-interval accumulators
    if (rx_evt_in.oof) next_s.oof_seen = 1'b1;
    if (!rx_evt_in.oof) next_s.oof_all = 1'b0;
    if (rx_evt_in.bit2_zero && s.b2z <= 5'(SF_B2_MAX)) next_s.b2z = s.b2z + 5'h01;
    if (rx_evt_in.ybit_zero && s.yz <= 3'(DM_Y_MAX)) next_s.yz = s.yz + 3'h1;
    if (rx_evt_in.yel_code_ok && s.code_ok < 4'(ESF_CODE_MIN)) begin
      next_s.code_ok = s.code_ok + 4'h1;
    end
    if (rx_evt_in.data_valid && !rx_evt_in.data && s.azero <= 7'(AIS_ZERO_MAX)) begin
      next_s.azero = s.azero + 7'h01;
    end
    if (rx_evt_in.f12_strobe) begin
      if (s.jy_seen && rx_evt_in.f12_val == s.jy_prev) next_s.jy_ok = 1'b0;
      next_s.jy_prev = rx_evt_in.f12_val;
      next_s.jy_seen = 1'b1;
    end

    // 40 ms and 60 ms decisions
    if (japan_mode_in) begin
      yel = s.jy_seen && s.jy_ok;
    end else begin
      case (s.fmode)
        FM_SF, FM_SLC:    yel = s.b2z <= 5'(SF_B2_MAX);
        FM_DM, FM_ALT_DM: yel = s.yz <= 3'(DM_Y_MAX);
        FM_ESF:           yel = s.code_ok >= 4'(ESF_CODE_MIN);
        default:          yel = 1'b0;
      endcase
    end
    if (end40) begin
      next_s.red_d    = s.oof_seen;
      next_s.yel_d    = yel;
      next_s.oof_seen = rx_evt_in.oof;
      next_s.b2z      = '0;
      next_s.yz       = '0;
      next_s.code_ok  = '0;
      next_s.jy_seen  = 1'b0;
      next_s.jy_ok    = 1'b1;
    end
    if (end60) begin
      next_s.ais_d   = s.oof_all && (s.azero <= 7'(AIS_ZERO_MAX));
      next_s.oof_all = rx_evt_in.oof;
      next_s.azero   = '0;
    end

    // alarm change flags, set wins over read clear
    next_s.alm_chg = (rd_alm ? 3'h0 : s.alm_chg)
                     | ({next_s.yel_d, next_s.red_d, next_s.ais_d} ^ old_alm);

    // receive density flags
    next_s.rx_density_change_flag = (rd_rx ? 1'b0 : s.rx_density_change_flag) | rx_chg;
    next_s.rx_z16i = (rd_rx ? 1'b0 : s.rx_z16i) | rx_z16;

    // transmit density flags
    next_s.stuff_occurred_flag   = (rd_tx ? 1'b0 : s.stuff_occurred_flag) | stuff_evt;
    next_s.tx_density_change_flag = (rd_tx ? 1'b0 : s.tx_density_change_flag) | tx_chg;
    next_s.tx_z16i = (rd_tx ? 1'b0 : s.tx_z16i) | tx_z16;
    if (s.stuff) begin
      next_s.tx_density_change_flag = 1'b0;
      next_s.tx_z16i = 1'b0;
    end

    // transmit data and loop code
    if (tx_in.valid) next_s.tx_data = tx_bit;
    next_s.tx_fdl = tx_in.fdl;
    if (s.code != CODE_OFF) begin
      if (tx_in.fdl_slot) begin
        next_s.tx_fdl  = pat[s.boc_idx];
        next_s.boc_idx = s.boc_idx + 4'h1;
      end
    end else begin
      next_s.boc_idx = '0;
    end

    // register writes
    if (wr) begin
      case (up_req_in.addr)
        ADDR_ALM_CFG: next_s.fmode = up_req_in.wdata[ALM_CFG_FMODE_LSB +: 3];
        ADDR_ALM_EN: begin
          next_s.fastd  = up_req_in.wdata[ALM_EN_FASTD];
          next_s.accel  = up_req_in.wdata[ALM_EN_ACCEL];
          next_s.alm_en = up_req_in.wdata[2:0];
        end
        ADDR_RX_DENS: begin
          if (!analog_bypass_select_in) begin
            next_s.rx_z16e = up_req_in.wdata[DENS_Z16E];
            next_s.rx_density_change_irq_enable = up_req_in.wdata[DENS_DENSITY_CHANGE_IRQ_ENABLE];
          end
        end
        ADDR_TX_CODE: begin
          next_s.code    = up_req_in.wdata[5:0];
          next_s.boc_idx = '0;
        end
        ADDR_TX_DENS: begin
          next_s.stuff_irq_enable   = up_req_in.wdata[TXD_STUFF_IRQ_ENABLE];
          next_s.stuff   = up_req_in.wdata[TXD_STUFF];
          next_s.tx_z16e = up_req_in.wdata[DENS_Z16E];
          next_s.tx_density_change_irq_enable = up_req_in.wdata[DENS_DENSITY_CHANGE_IRQ_ENABLE];
        end
        default: ;
      endcase
    end

    // register reads
    next_s.rdata = 8'h00;
    if (up_req_in.rd) begin
      case (up_req_in.addr)
        ADDR_ALM_CFG:  next_s.rdata = {3'h0, s.fmode, 2'h0};
        ADDR_ALM_EN:   next_s.rdata = {3'h0, s.fastd, s.accel, s.alm_en};
        ADDR_ALM_STAT: next_s.rdata = {2'h0, s.alm_chg, old_alm};
        ADDR_ALM_DET:  next_s.rdata = {5'h00, s.red_d, s.yel_d, s.ais_d};
        ADDR_RX_DENS: begin
          if (!analog_bypass_select_in) begin
            next_s.rdata = {3'h0, rx_viol, s.rx_z16i, s.rx_density_change_flag, s.rx_z16e, s.rx_density_change_irq_enable};
          end
        end
        ADDR_TX_CODE:  next_s.rdata = {2'h0, s.code};
        ADDR_TX_DENS:  next_s.rdata = {s.stuff_irq_enable, s.stuff, s.stuff_occurred_flag,
                                       {tx_viol, s.tx_z16i, s.tx_density_change_flag} & {3{!s.stuff}},
                                       s.tx_z16e, s.tx_density_change_irq_enable};
        default:       next_s.rdata = 8'h00;
      endcase
    end

    // shared interrupt
    next_s.irq_n = !(|(next_s.alm_chg & next_s.alm_en)
                     || (next_s.rx_density_change_flag && next_s.rx_density_change_irq_enable)
                     || (next_s.rx_z16i && next_s.rx_z16e)
                     || (next_s.stuff_occurred_flag && next_s.stuff_irq_enable)
                     || (next_s.tx_density_change_flag && next_s.tx_density_change_irq_enable && !next_s.stuff)
                     || (next_s.tx_z16i && next_s.tx_z16e && !next_s.stuff));

    if (e1_mode_select_in) begin
      next_s = S_RST;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= S_RST;
    end else if (clk_en_in) begin
      s <= next_s;
    end
  end

  assign up_rdata_out    = s.rdata;
  assign interrupt_out_n = s.irq_n;
  assign tx_data_out     = s.tx_data;
  assign tx_fdl_out      = s.tx_fdl;

endmodule

// ### verification/tadm_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module tadm_monitor
  import tadm_pkg::*;
#(
  parameter int RED_CYC = RED_WIN_CYC,
  parameter int AIS_CYC = AIS_WIN_CYC
) (
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clk_en_in,
  // configuration
  input  wire logic         e1_mode_select_in,
  input  wire logic         analog_bypass_select_in,
  // register access
  input  wire tadm_up_req_s up_req_in,
  input  wire logic [7:0]   up_rdata_out,
  input  wire logic         interrupt_out_n,
  // streams
  input  wire tadm_tx_in_s  tx_in,
  input  wire logic         tx_data_out,
  input  wire tadm_rx_evt_s rx_evt_in,
  input  wire logic         tx_fdl_out
);
  typedef struct packed {
    logic [5:0] code;
    logic       stf;
    logic [4:0] zr;
    logic       vd;
    logic [4:0] tz;
  } tadm_mon_s;

  tadm_mon_s st;
  tadm_mon_s next_st;
  logic      run;
  logic      rd;

  assign run = clk_en_in && !e1_mode_select_in;
  assign rd  = run && up_req_in.rd;

  // ----------------------------------------------------------------
  // shadow of code, stuffing and zero runs
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (run && up_req_in.wr && up_req_in.addr == ADDR_TX_CODE)
      next_st.code = up_req_in.wdata[5:0];
    if (run && up_req_in.wr && up_req_in.addr == ADDR_TX_DENS)
      next_st.stf = up_req_in.wdata[TXD_STUFF];
    if (run && rx_evt_in.data_valid)
      next_st.zr = rx_evt_in.data ? 5'h00 : ((st.zr == 5'h10) ? st.zr : st.zr + 5'h01);
    next_st.vd = run && tx_in.valid;
    if (st.vd)
      next_st.tz = tx_data_out ? 5'h00 : st.tz + 5'h01;
    if (!st.stf)
      next_st.tz = 5'h00;
    if (clk_en_in && e1_mode_select_in)
      next_st = '{code: CODE_OFF, default: '0};
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      st <= '{code: CODE_OFF, default: '0};
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  AST_E1_OUTS: assert property (e1_mode_select_in && clk_en_in |=>
    interrupt_out_n && !tx_data_out && !tx_fdl_out) else $error("outputs not reset in e1");
  AST_E1_READ: assert property ((e1_mode_select_in && clk_en_in) [*2] ##0
    (up_req_in.rd && up_req_in.addr != ADDR_TX_CODE) |=> up_rdata_out == 8'h00)
    else $error("register not held reset in e1");
  AST_BYP_READ: assert property (clk_en_in && up_req_in.rd && analog_bypass_select_in
    && up_req_in.addr == ADDR_RX_DENS |=> up_rdata_out == 8'h00) else $error("bypass read");
  AST_CODE_BACK: assert property (rd && up_req_in.addr == ADDR_TX_CODE |=>
    up_rdata_out == {2'h0, $past(st.code)}) else $error("code readback");
  AST_FDL_PASS: assert property (run && st.code == CODE_OFF && tx_in.fdl_slot |=>
    tx_fdl_out == $past(tx_in.fdl)) else $error("link bit not passed");
  AST_STUF_QUIET: assert property (rd && up_req_in.addr == ADDR_TX_DENS ##1
    up_rdata_out[TXD_STUFF] |-> up_rdata_out[4:2] == 3'h0) else $error("flags while stuffing");
  AST_ZRUN_PDV: assert property (rd && !analog_bypass_select_in
    && up_req_in.addr == ADDR_RX_DENS && st.zr == 5'h10 && $past(st.zr, 2) == 5'h10
    |=> up_rdata_out[DENS_PDV]) else $error("zero run not a violation");
  AST_STUF_RUN: assert property (st.stf |-> st.tz < 5'h10)
    else $error("sixteen zeros sent while stuffing");
  AST_IRQ_RISE: assert property ($rose(interrupt_out_n) |->
    $past(up_req_in.rd || up_req_in.wr || e1_mode_select_in)) else $error("irq dropped");

  cover property (st.stf && st.vd && tx_data_out);
  cover property (!interrupt_out_n ##1 interrupt_out_n);
  cover property (st.zr == 5'h10);
endmodule

bind tadm_top tadm_monitor #(.RED_CYC(RED_CYC), .AIS_CYC(AIS_CYC)) mon_u (
  .mclk_in, .sys_rst_in, .clk_en_in, .e1_mode_select_in, .analog_bypass_select_in,
  .up_req_in, .up_rdata_out, .interrupt_out_n, .tx_in, .tx_data_out, .rx_evt_in,
  .tx_fdl_out);

// ### verification/tadm_line_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-end line: paced receive and transmit streams
// ----------------------------------------------------------------
module tadm_line_model
  import tadm_pkg::*;
(
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  // line conditions
  input  wire logic   oof_in,
  input  wire logic   rx_zero_in,
  input  wire logic   tx_zero_in,
  // streams
  output tadm_rx_evt_s rx_evt_out,
  output tadm_tx_in_s  tx_out
);
  logic [1:0] div;
  logic       fl;

  // one bit every four clocks; unqualified cycles carry a changing pattern
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div <= 2'h0;
      fl <= 1'b0;
      rx_evt_out <= '0;
      tx_out <= '0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h2)
        fl <= ~fl;
      rx_evt_out <= '{oof: oof_in, data: (div == 2'h0) ? !rx_zero_in : div[0],
                      data_valid: (div == 2'h0), default: 1'b0};
      tx_out <= '{data: (div == 2'h0) ? !tx_zero_in : div[0], valid: (div == 2'h0),
                  fdl_slot: (div == 2'h2), fdl: (div == 2'h2) ? ~fl : div[0]};
    end
  end
endmodule

// ### verification/test_tadm_top.sv
`timescale 1ns/1ps
module test_tadm_top
  import tadm_pkg::*;
();
  localparam logic [7:0] RA [7] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h69};
  logic         mclk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         e1 = 1'b0;
  logic         byp = 1'b0;
  logic         oof = 1'b0;
  logic         rx_zero = 1'b0;
  logic         tx_zero = 1'b0;
  tadm_up_req_s req = '0;
  tadm_rx_evt_s evt;
  tadm_tx_in_s  txs;
  logic [7:0]   rdata;
  logic         irq_n;
  logic         txd;
  logic         fdl;
  int           n_errors = 0;
  int           compares = 0;
  int           cyc = 0;

  initial forever #20 mclk_in = ~mclk_in;

  tadm_top #(.RED_CYC(200), .AIS_CYC(300)) dut_u (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .e1_mode_select_in(e1), .analog_bypass_select_in(byp), .japan_mode_in(1'b0),
    .up_req_in(req), .up_rdata_out(rdata), .interrupt_out_n(irq_n),
    .rx_evt_in(evt), .tx_in(txs), .tx_data_out(txd), .tx_fdl_out(fdl));

  tadm_line_model line_u (
    .clk_in(mclk_in), .rst_in(sys_rst_in), .oof_in(oof), .rx_zero_in(rx_zero),
    .tx_zero_in(tx_zero), .rx_evt_out(evt), .tx_out(txs));

  // ----------------------------------------------------------------
  // access and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req <= '0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req <= '0;
    #1 chk(rdata, e, $sformatf("read %h", a));
  endtask

  task automatic irq(input logic e);
    chk({7'h0, irq_n}, {7'h0, e}, "interrupt");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    if (!sys_rst_in)
      cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] p;
    logic        b;
    p = {1'b0, 6'h05, 1'b0, 8'hff};
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    foreach (RA[i]) rc(RA[i], 8'h00);
    rc(ADDR_TX_CODE, 8'h3f);
    wr(ADDR_ALM_EN, 8'h02);
    fin("reset");
    while (cyc < 215) idle(1);
    irq(1'b1);
    rc(ADDR_ALM_STAT, 8'h24);
    oof <= 1'b1;
    while (cyc < 615) idle(1);
    irq(1'b0);
    rc(ADDR_ALM_DET, 8'h07);
    rc(ADDR_ALM_STAT, 8'h1f);
    irq(1'b1);
    oof <= 1'b0;
    wr(ADDR_ALM_EN, 8'h00);
    wr(ADDR_ALM_CFG, 8'h10);
    while (cyc < 815) idle(1);
    rc(ADDR_ALM_DET, 8'h05);
    rc(ADDR_ALM_STAT, 8'h23);
    wr(ADDR_ALM_CFG, 8'h04);
    while (cyc < 1015) idle(1);
    rc(ADDR_ALM_DET, 8'h02);
    fin("alarms");
    wr(ADDR_RX_DENS, 8'h02);
    rx_zero <= 1'b1;
    idle(84);
    rx_zero <= 1'b0;
    idle(12);
    irq(1'b0);
    rc(ADDR_RX_DENS, 8'h0e);
    irq(1'b1);
    wr(ADDR_RX_DENS, 8'h01);
    rx_zero <= 1'b1;
    idle(84);
    irq(1'b0);
    rc(ADDR_RX_DENS, 8'h1d);
    irq(1'b1);
    rx_zero <= 1'b0;
    idle(12);
    irq(1'b0);
    rc(ADDR_RX_DENS, 8'h05);
    byp <= 1'b1;
    rc(ADDR_RX_DENS, 8'h00);
    wr(ADDR_RX_DENS, 8'h00);
    byp <= 1'b0;
    rc(ADDR_RX_DENS, 8'h01);
    fin("receive density");
    tx_zero <= 1'b1;
    idle(84);
    chk({7'h0, txd}, 8'h00, "passed bit");
    tx_zero <= 1'b0;
    idle(12);
    rc(ADDR_TX_DENS, 8'h0c);
    wr(ADDR_TX_DENS, 8'hc0);
    tx_zero <= 1'b1;
    idle(84);
    irq(1'b0);
    tx_zero <= 1'b0;
    idle(12);
    rc(ADDR_TX_DENS, 8'he0);
    irq(1'b1);
    rc(ADDR_TX_DENS, 8'hc0);
    fin("transmit density");
    wr(ADDR_TX_CODE, 8'h05);
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk_in iff txs.fdl_slot);
      #1 chk({7'h0, fdl}, {7'h0, p[i % 16]}, "code bit");
    end
    rc(ADDR_TX_CODE, 8'h05);
    wr(ADDR_TX_CODE, 8'h3f);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in iff txs.fdl_slot);
      b = txs.fdl;
      #1 chk({7'h0, fdl}, {7'h0, b}, "link bit");
    end
    fin("loop code");
    e1 <= 1'b1;
    idle(2);
    rc(ADDR_TX_DENS, 8'h00);
    e1 <= 1'b0;
    rc(ADDR_TX_CODE, 8'h3f);
    rc(ADDR_RX_DENS, 8'h00);
    fin("e1 hold");
    tally_and_finish();
  end
endmodule
